// *** rtl/tpwm_core.sv ***
// Functional notes
// R1 - fast modes 5,6,7,14,15 count up bottom to top, then restart at bottom
// R2 - fast top: 0x00FF/0x01FF/0x03FF for 5/6/7, capture_top_value 14, compare_a_value 15
// R3 - fast: counter at top clears to bottom on next timer tick
// R4 - fast: select 2 clears on match, sets at top; select 3 inverse
// R5 - fast: overflow_flag at top; compare_a_flag/capture_flag too when defining top
// R6 - count equal to a compare_value sets that channel's compare flag
// R7 - fixed top modes mask compare writes above resolution to zero
// R8 - capture_top_value unbuffered; below count, counter wraps via 0xFFFF
// R9 - fast: compare writes buffered, loaded at top with clear and overflow
// R10 - fast: compare 0 gives one-tick spike; compare equal top gives constant level
// R11 - fast: channel a select 1 toggles on match, only in mode 15
// R12 - dual modes 1,2,3,10,11 count up to top then down to bottom
// R13 - dual top: fixed for 1/2/3, capture_top_value 10, compare_a_value 11
// R14 - dual: count stays at top one tick before going down
// R15 - dual: select 2 clears on up match, sets on down match; 3 inverse
// R16 - dual: overflow_flag set at bottom, not top
// R17 - dual: buffers load at top; top-defining flag set at top
// R18 - dual: compare at bottom gives low, at top high; inverted opposite
// R19 - dual: channel a select 1 toggles on match in mode 11
// R20 - waveform reaches pin only when pin_direction_bit is output
// R21 - software keeps register top between 0x0003 and 0xFFFF
// R22 - top below a compare_value gives no match on that channel
// R23 - software should not change top on the fly in dual mode
// R24 - select 0 takes no action on compare_output
// R25 - reset clears compare_output state to zero
// R26 - counter, flags and pwm-mode loads advance only on timer ticks
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ns
`include "tpwm_params.svh"

module tpwm_core (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // prescaled timer tick
  input  wire logic        timer_tick,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // compare output pins, channel a in bit 0
  output logic      [1:0]  pin_o,
  output logic      [1:0]  pin_oe
);

  tpwm_pkg::tpwm_state_t q;
  tpwm_pkg::tpwm_state_t d;

  function automatic logic is_fast(input logic [3:0] m);
    is_fast = (m == `TPWM_M_FAST8) || (m == `TPWM_M_FAST9) || (m == `TPWM_M_FAST10)
           || (m == `TPWM_M_FS_CAP) || (m == `TPWM_M_FS_CMPA);
  endfunction

  function automatic logic is_dual(input logic [3:0] m);
    is_dual = (m == `TPWM_M_PC8) || (m == `TPWM_M_PC9) || (m == `TPWM_M_PC10)
           || (m == `TPWM_M_PC_CAP) || (m == `TPWM_M_PC_CMPA);
  endfunction

  // fixed resolution mask, all ones when top comes from a register
  function automatic logic [15:0] fix_mask(input logic [3:0] m);
    if (m == `TPWM_M_FAST8 || m == `TPWM_M_PC8) begin
      fix_mask = `TPWM_TOP8;
    end else if (m == `TPWM_M_FAST9 || m == `TPWM_M_PC9) begin
      fix_mask = `TPWM_TOP9;
    end else if (m == `TPWM_M_FAST10 || m == `TPWM_M_PC10) begin
      fix_mask = `TPWM_TOP10;
    end else begin
      fix_mask = 16'hFFFF;
    end
  endfunction

  function automatic logic top_is_cap(input logic [3:0] m);
    top_is_cap = (m == `TPWM_M_FS_CAP) || (m == `TPWM_M_PC_CAP);
  endfunction

  function automatic logic top_is_cmpa(input logic [3:0] m);
    top_is_cmpa = (m == `TPWM_M_FS_CMPA) || (m == `TPWM_M_PC_CMPA);
  endfunction

  logic        fast;
  logic        dual;
  logic [15:0] top;
  logic        at_top;
  logic        at_bot;
  logic [1:0]  match;
  logic        up_eff;
  logic        acc;
  logic [3:0]  fset;   // this cycle's flag events, kept apart so a clear cannot hide them

  // mode decode and top select
  always_comb begin
    fast = is_fast(q.mode);                                   // [R1]
    dual = is_dual(q.mode);                                   // [R12]
    if (top_is_cap(q.mode)) begin
      top = q.cap;                                            // [R2] [R13] [R8]
    end else if (top_is_cmpa(q.mode)) begin
      top = q.ocr[0];                                         // [R2] [R13]
    end else begin
      top = fix_mask(q.mode);                                 // [R2] [R13]
    end
    at_top = (q.cnt == top);
    at_bot = (q.cnt == `TPWM_BOTTOM);
    // a match at bottom counts as upward, at top as downward
    up_eff = at_bot ? 1'b1 : (at_top ? 1'b0 : (q.dir == tpwm_pkg::TPWM_UP));
    for (int i = 0; i < 2; i++) begin
      match[i] = (q.cnt == q.ocr[i]) && (q.ocr[i] <= top);   // [R22]
    end
    acc = psel && penable && !q.pready;
  end

  // next state: bus, counter, flags and outputs
  always_comb begin
    d = q;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    fset      = 4'h0;
    // timer events, only on a tick
    if (timer_tick && (fast || dual)) begin                   // [R26]
      if (fast) begin
        d.cnt = at_top ? `TPWM_BOTTOM : 16'(q.cnt + 16'h0001);  // [R1] [R3] [R8]
        d.dir = tpwm_pkg::TPWM_UP;
        if (at_top) begin
          d.ocr = q.buf_v;                                    // [R9]
          fset[`TPWM_FLG_OVF] = 1'b1;                         // [R5]
        end
      end else begin
        if (q.dir == tpwm_pkg::TPWM_UP && at_top) begin
          d.dir = tpwm_pkg::TPWM_DOWN;                        // [R14]
          d.cnt = 16'(q.cnt - 16'h0001);
        end else if (q.dir == tpwm_pkg::TPWM_DOWN && at_bot) begin
          d.dir = tpwm_pkg::TPWM_UP;
          d.cnt = 16'(q.cnt + 16'h0001);
          fset[`TPWM_FLG_OVF] = 1'b1;                         // [R16]
        end else if (q.dir == tpwm_pkg::TPWM_UP) begin
          d.cnt = 16'(q.cnt + 16'h0001);                      // [R12] [R8]
        end else begin
          d.cnt = 16'(q.cnt - 16'h0001);                      // [R12]
        end
        if (at_top) begin
          d.ocr = q.buf_v;                                    // [R17]
        end
      end
      if (at_top && top_is_cap(q.mode)) begin
        fset[`TPWM_FLG_CAP] = 1'b1;                           // [R5] [R17]
      end
      // compare_a as top matches at top, so its flag rises there too
      if (match[0]) begin
        fset[`TPWM_FLG_CMPA] = 1'b1;                          // [R6] [R5] [R17]
      end
      if (match[1]) begin
        fset[`TPWM_FLG_CMPB] = 1'b1;                          // [R6]
      end
      for (int i = 0; i < 2; i++) begin
        if (q.act[i] == `TPWM_ACT_TOGGLE) begin
          // toggle only for channel a with compare_a as top
          if (i == 0 && match[0] && top_is_cmpa(q.mode)) begin
            d.oc[0] = ~q.oc[0];                               // [R11] [R19]
          end
        end else if (q.act[i] != `TPWM_ACT_OFF) begin         // [R24]
          if (fast) begin
            // set at top wins, so compare equal top holds a steady level
            if (at_top) begin
              d.oc[i] = (q.act[i] == `TPWM_ACT_NONINV);       // [R4] [R10]
            end else if (match[i]) begin
              d.oc[i] = (q.act[i] == `TPWM_ACT_INV);          // [R4] [R10]
            end
          end else if (match[i]) begin
            d.oc[i] = up_eff ? (q.act[i] == `TPWM_ACT_INV)
                             : (q.act[i] == `TPWM_ACT_NONINV); // [R15] [R18]
          end
        end
      end
    end
    // flags only set here; a clear below keeps these events
    d.flags = q.flags | fset;
    // without a pwm mode the buffers are transparent
    if (!(fast || dual)) begin
      d.ocr = q.buf_v;
    end
    // apb access, answered one cycle into the access phase
    if (acc) begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      if (paddr == `TPWM_OFF_CTRL) begin
        if (pwrite) begin
          d.mode    = pwdata[`TPWM_CTRL_MODE_LSB +: 4];
          d.act[0]  = pwdata[`TPWM_CTRL_ACTA_LSB +: 2];
          d.act[1]  = pwdata[`TPWM_CTRL_ACTB_LSB +: 2];
          d.pdir[0] = pwdata[`TPWM_CTRL_DIRA_BIT];
          d.pdir[1] = pwdata[`TPWM_CTRL_DIRB_BIT];
        end else begin
          d.prdata = {22'h0, q.pdir, q.act[1], q.act[0], q.mode};
        end
      end else if (paddr == `TPWM_OFF_COUNT) begin
        if (pwrite) begin
          d.cnt = pwdata[15:0];
        end else begin
          d.prdata = {16'h0000, q.cnt};
        end
      end else if (paddr == `TPWM_OFF_CMPA || paddr == `TPWM_OFF_CMPB) begin
        if (pwrite) begin
          // mask uses the mode in force at the write
          if (paddr == `TPWM_OFF_CMPA) begin
            d.buf_v[0] = pwdata[15:0] & fix_mask(q.mode);     // [R7] [R9]
          end else begin
            d.buf_v[1] = pwdata[15:0] & fix_mask(q.mode);     // [R7] [R9]
          end
        end else begin
          d.prdata = {16'h0000, q.buf_v[paddr == `TPWM_OFF_CMPB]};
        end
      end else if (paddr == `TPWM_OFF_CAPTOP) begin
        if (pwrite) begin
          d.cap = pwdata[15:0];                               // [R8]
        end else begin
          d.prdata = {16'h0000, q.cap};
        end
      end else if (paddr == `TPWM_OFF_FLAGS) begin
        if (pwrite) begin
          // write one to clear; a flag set by this cycle's tick survives
          d.flags = (q.flags & ~pwdata[3:0]) | fset;
        end else begin
          d.prdata = {28'h0, q.flags};
        end
      end else begin
        d.pslverr = 1'b1;
      end
    end
    // pin drive gated by direction and an active select
    for (int i = 0; i < 2; i++) begin
      d.pin_o[i]  = d.oc[i];
      d.pin_oe[i] = d.pdir[i] && (d.act[i] != `TPWM_ACT_OFF); // [R20]
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q <= '0;                                                // [R25]
    end else begin
      q <= d;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign pin_o   = q.pin_o;
  assign pin_oe  = q.pin_oe;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // fast wrap from top to bottom
  AST_FAST_WRAP: assert property (                            // [R3]
    timer_tick && fast && at_top && !acc |=> q.cnt == `TPWM_BOTTOM)
    else $error("fast counter did not clear after top");

  // dual turns at top and steps down to top minus one on the same tick
  AST_DUAL_TURN: assert property (                            // [R14]
    timer_tick && dual && at_top && q.dir == tpwm_pkg::TPWM_UP && !acc
    |=> q.dir == tpwm_pkg::TPWM_DOWN && q.cnt == 16'($past(q.cnt) - 16'h0001))
    else $error("dual counter did not reverse at top");

  // fast overflow at top, dual overflow at bottom
  AST_FAST_OVF: assert property (                             // [R5]
    timer_tick && fast && at_top |=> q.flags[`TPWM_FLG_OVF])
    else $error("fast overflow flag missing at top");

  AST_DUAL_OVF: assert property (                             // [R16]
    timer_tick && dual && at_bot && q.dir == tpwm_pkg::TPWM_DOWN
    |=> q.flags[`TPWM_FLG_OVF])
    else $error("dual overflow flag missing at bottom");

  // buffer loads into the active compare at top
  AST_BUF_LOAD: assert property (                             // [R9]
    timer_tick && (fast || dual) && at_top |=> q.ocr[1] == $past(q.buf_v[1]))
    else $error("compare b not loaded at top");

  // compare b flag follows a valid match
  AST_CMP_FLAG: assert property (                             // [R6]
    timer_tick && (fast || dual) && match[1] |=> q.flags[`TPWM_FLG_CMPB])
    else $error("compare b flag missing after match");

  // select zero leaves the output untouched
  AST_NO_ACTION: assert property (                             // [R24]
    q.act[1] == `TPWM_ACT_OFF |=> q.oc[1] == $past(q.oc[1]))
    else $error("output b changed with select zero");

  // pin enable tracks direction bit
  AST_PIN_GATE: assert property (                              // [R20]
    !q.pdir[0] ##1 !q.pdir[0] |-> !pin_oe[0])
    else $error("pin a driven with direction input");

  // fixed mode masks compare writes
  AST_MASK: assert property (                                  // [R7]
    acc && pwrite && paddr == `TPWM_OFF_CMPB && q.mode == `TPWM_M_FAST8
    |=> q.buf_v[1][15:8] == 8'h00)
    else $error("compare write not masked in fixed mode");

  // counter holds without a tick
  AST_TICK_HOLD: assert property (                             // [R26]
    !timer_tick && !acc |=> q.cnt == $past(q.cnt))
    else $error("counter moved without a tick");

  // reset leaves both output states low, checked while reset is high too
  AST_RST_OC: assert property (                                // [R25]
    disable iff (1'b0) sys_rst |=> q.oc == 2'h0)
    else $error("output state not cleared by reset");

  // a compare above top never raises its flag
  AST_NO_MATCH: assert property (                              // [R22]
    (fast || dual) && q.ocr[0] > top && !q.flags[`TPWM_FLG_CMPA]
    |=> !q.flags[`TPWM_FLG_CMPA])
    else $error("compare a flag set with compare above top");

  // fast non-inverted: set at top, clear on a match below top
  AST_FAST_SET: assert property (                              // [R4]
    timer_tick && fast && q.act[1] == `TPWM_ACT_NONINV && at_top |=> q.oc[1])
    else $error("fast output b not set at top");

  AST_FAST_CLR: assert property (                              // [R4]
    timer_tick && fast && q.act[1] == `TPWM_ACT_NONINV && match[1] && !at_top
    |=> !q.oc[1])
    else $error("fast output b not cleared on match");

  // dual non-inverted clears on an upward match
  AST_DUAL_UP: assert property (                               // [R15]
    timer_tick && dual && q.act[1] == `TPWM_ACT_NONINV && match[1]
    && q.dir == tpwm_pkg::TPWM_UP && !at_top |=> !q.oc[1])
    else $error("dual output b not cleared on upward match");

  // toggle on every match when compare a sets top
  AST_TOGGLE: assert property (                                // [R11] [R19]
    timer_tick && top_is_cmpa(q.mode) && q.act[0] == `TPWM_ACT_TOGGLE && match[0]
    |=> q.oc[0] != $past(q.oc[0]))
    else $error("output a did not toggle on match");

  // capture register as top raises its flag at top
  AST_CAP_FLAG: assert property (                              // [R5] [R17]
    timer_tick && (fast || dual) && top_is_cap(q.mode) && at_top
    |=> q.flags[`TPWM_FLG_CAP])
    else $error("capture flag missing at top");

endmodule // tpwm_core

// *** rtl/tpwm_params.svh ***
`ifndef TPWM_PARAMS_SVH
`define TPWM_PARAMS_SVH

// register byte offsets
`define TPWM_OFF_CTRL   8'h00
`define TPWM_OFF_COUNT  8'h04
`define TPWM_OFF_CMPA   8'h08
`define TPWM_OFF_CMPB   8'h0C
`define TPWM_OFF_CAPTOP 8'h10
`define TPWM_OFF_FLAGS  8'h14

// control register fields
`define TPWM_CTRL_MODE_LSB  0
`define TPWM_CTRL_ACTA_LSB  4
`define TPWM_CTRL_ACTB_LSB  6
`define TPWM_CTRL_DIRA_BIT  8
`define TPWM_CTRL_DIRB_BIT  9

// flag register bits
`define TPWM_FLG_OVF   0
`define TPWM_FLG_CMPA  1
`define TPWM_FLG_CMPB  2
`define TPWM_FLG_CAP   3

// waveform mode codes
`define TPWM_M_PC8     4'h1
`define TPWM_M_PC9     4'h2
`define TPWM_M_PC10    4'h3
`define TPWM_M_FAST8   4'h5
`define TPWM_M_FAST9   4'h6
`define TPWM_M_FAST10  4'h7
`define TPWM_M_PC_CAP  4'hA
`define TPWM_M_PC_CMPA 4'hB
`define TPWM_M_FS_CAP  4'hE
`define TPWM_M_FS_CMPA 4'hF

// fixed tops and counter limits
`define TPWM_TOP8    16'h00FF
`define TPWM_TOP9    16'h01FF
`define TPWM_TOP10   16'h03FF
`define TPWM_BOTTOM  16'h0000

// output action codes
`define TPWM_ACT_OFF    2'h0
`define TPWM_ACT_TOGGLE 2'h1
`define TPWM_ACT_NONINV 2'h2
`define TPWM_ACT_INV    2'h3

// reset values
`define TPWM_RST_WORD 16'h0000

`endif

// *** rtl/tpwm_pkg.sv ***
package tpwm_pkg;

  typedef enum logic {
    TPWM_UP,
    TPWM_DOWN
  } tpwm_dir_t;

  // all state of the pwm block
  typedef struct packed {
    logic [15:0]       cnt;
    tpwm_dir_t         dir;
    logic [1:0][15:0]  ocr;
    logic [1:0][15:0]  buf_v;
    logic [15:0]       cap;
    logic [3:0]        mode;
    logic [1:0][1:0]   act;
    logic [1:0]        pdir;
    logic [1:0]        oc;
    logic [3:0]        flags;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [1:0]        pin_o;
    logic [1:0]        pin_oe;
  } tpwm_state_t;

endpackage

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`include "tpwm_params.svh"
module tb_top;
  // drive and observe
  logic        ref_clk;
  logic        sys_rst;
  logic        timer_tick;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pin_o;
  logic [1:0]  pin_oe;
  logic [31:0] rdata;
  logic        rerr;
  logic [31:0] keep;
  int          high_a;
  int          high_b;
  int          sa;
  int          sb;
  int          cyc = 0;
  int          bad_count = 0;
  int          total_checks = 0;
  logic [3:0]  fmode [6] = '{4'h5, 4'h6, 4'h7, 4'h1, 4'h2, 4'h3};
  logic [15:0] fmask [6] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h00FF, 16'h01FF, 16'h03FF};

  tpwm_core tpwm_core_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .timer_tick(timer_tick),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_o(pin_o), .pin_oe(pin_oe)
  );

  tpwm_load tpwm_load_inst (
    .ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe),
    .high_a(high_a), .high_b(high_b)
  );

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // the tests need about 17000 cycles, so this only trips on a hang
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count = bad_count + 1;
      conclude();
    end
  end

  // counts, verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // compare a bus or pin value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // compare a tally of high pin cycles
  task automatic chk_n(input int got, input int exp, input string what);
    total_checks++;
    if (got != exp) begin
      bad_count++;
      $display("BAD t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high or 16 cycles pass
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk({31'h0, pready}, 32'h0000_0001, "pready");
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // let the timer advance by exactly n ticks, then hold it
  task automatic tick_run(input int n);
    timer_tick <= 1'b1;
    repeat (n) @(posedge ref_clk);
    timer_tick <= 1'b0;
  endtask

  // set up one waveform from idle, settle two windows, tally one window
  task automatic pwm_case(input logic [3:0] m, input logic [15:0] top,
      input logic [15:0] ca, input logic [15:0] cb, input logic [1:0] aa,
      input logic [1:0] ab, input logic [1:0] d, input int w, input int ea, input int eb);
    apb(`TPWM_OFF_CTRL, 1'b1, 32'h0000_0000);
    apb(`TPWM_OFF_COUNT, 1'b1, 32'h0000_0000);
    apb(`TPWM_OFF_CAPTOP, 1'b1, {16'h0000, top});
    apb(`TPWM_OFF_CMPA, 1'b1, {16'h0000, ca});
    apb(`TPWM_OFF_CMPB, 1'b1, {16'h0000, cb});
    apb(`TPWM_OFF_CTRL, 1'b1, {22'h0, d, ab, aa, m});
    repeat (2 * w) @(posedge ref_clk);
    sa = high_a;
    sb = high_b;
    repeat (w) @(posedge ref_clk);
    chk_n(high_a - sa, ea, "high a");
    chk_n(high_b - sb, eb, "high b");
    chk({30'h0, pin_oe}, {30'h0, d}, "pin drive");
    $display("case done mode %0h window %0d", m, w);
  endtask

  // main sequence; register tops kept within 0x0003..0xFFFF
  initial begin
    sys_rst = 1'b1;
    timer_tick = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    timer_tick <= 1'b1;
    chk({30'h0, pin_o}, 32'h0000_0000, "reset level");
    for (int i = 0; i < 6; i++) begin
      apb(8'(4 * i), 1'b0, 32'h0000_0000);
      chk(rdata, 32'h0000_0000, "reset value");
    end
    apb(8'h18, 1'b0, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001, "unmapped error");
    chk(rdata, 32'h0000_0000, "unmapped data");
    $display("test done reset and map");
    for (int i = 0; i < 6; i++) begin
      apb(`TPWM_OFF_CTRL, 1'b1, {28'h0, fmode[i]});
      apb(`TPWM_OFF_CMPB, 1'b1, 32'h0000_FFFF);
      apb(`TPWM_OFF_CMPB, 1'b0, 32'h0000_0000);
      chk(rdata, {16'h0, fmask[i]}, "masked compare");
    end
    $display("test done masking");
    pwm_case(4'hE, 16'h0003, 16'h0000, 16'h0001, 2'h2, 2'h3, 2'h3, 4, 1, 2);
    pwm_case(4'hE, 16'h0003, 16'h0005, 16'h0003, 2'h2, 2'h3, 2'h3, 4, 4, 0);
    apb(`TPWM_OFF_FLAGS, 1'b1, 32'h0000_000F);
    repeat (8) @(posedge ref_clk);
    apb(`TPWM_OFF_FLAGS, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_000D, "flags");
    @(posedge ref_clk);
    timer_tick <= 1'b0;
    apb(`TPWM_OFF_COUNT, 1'b0, 32'h0000_0000);
    keep = rdata;
    repeat (6) @(posedge ref_clk);
    apb(`TPWM_OFF_COUNT, 1'b0, 32'h0000_0000);
    chk(rdata, keep, "count held");
    $display("test done flags and hold");
    // mode 14 with top 3 and active compare b 3; new b value must wait for top
    apb(`TPWM_OFF_COUNT, 1'b1, 32'h0000_0000);
    apb(`TPWM_OFF_CMPB, 1'b1, 32'h0000_0001);
    apb(`TPWM_OFF_FLAGS, 1'b1, 32'h0000_000F);
    tick_run(2);
    apb(`TPWM_OFF_FLAGS, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_0000, "no early load");
    tick_run(2);
    apb(`TPWM_OFF_FLAGS, 1'b1, 32'h0000_000F);
    tick_run(2);
    apb(`TPWM_OFF_FLAGS, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_0004, "load at top");
    // count above the capture top runs on past it
    apb(`TPWM_OFF_COUNT, 1'b1, 32'h0000_0008);
    tick_run(5);
    apb(`TPWM_OFF_COUNT, 1'b0, 32'h0000_0000);
    chk(rdata, 32'h0000_000D, "run past top");
    $display("test done buffering and top");
    timer_tick <= 1'b1;
    pwm_case(4'h5, 16'h0003, 16'h007F, 16'h00FF, 2'h2, 2'h3, 2'h3, 256, 128, 0);
    pwm_case(4'h6, 16'h0003, 16'h007F, 16'h01FF, 2'h2, 2'h2, 2'h3, 512, 128, 512);
    pwm_case(4'h7, 16'h0003, 16'h03FF, 16'h0080, 2'h2, 2'h3, 2'h3, 1024, 1024, 895);
    pwm_case(4'hA, 16'h0004, 16'h0000, 16'h0001, 2'h2, 2'h3, 2'h3, 8, 0, 6);
    pwm_case(4'hA, 16'h0004, 16'h0004, 16'h0003, 2'h2, 2'h2, 2'h3, 8, 8, 6);
    pwm_case(4'h1, 16'h0003, 16'h007F, 16'h00FF, 2'h2, 2'h3, 2'h3, 510, 254, 0);
    pwm_case(4'h2, 16'h0003, 16'h0000, 16'h01FF, 2'h3, 2'h3, 2'h3, 1022, 1022, 0);
    pwm_case(4'h3, 16'h0003, 16'h0100, 16'h03FF, 2'h3, 2'h2, 2'h3, 2046, 1534, 2046);
    pwm_case(4'hF, 16'h0003, 16'h0003, 16'h0002, 2'h1, 2'h2, 2'h3, 8, 4, 6);
    pwm_case(4'hB, 16'h0003, 16'h0003, 16'h0001, 2'h1, 2'h2, 2'h3, 12, 6, 4);
    pwm_case(4'hE, 16'h0003, 16'h0003, 16'h0003, 2'h2, 2'h2, 2'h2, 4, 0, 4);
    conclude();
  end
endmodule // tb_top

// *** sim/tpwm_load.sv ***
`timescale 1ns/1ns
// load on both compare pins, pulled low whenever a pin is not driven
module tpwm_load (
  // clock
  input  wire logic       ref_clk,
  // pins from the block, channel a in bit 0
  input  wire logic [1:0] pin_o,
  input  wire logic [1:0] pin_oe,
  // running tallies of high samples
  output int              high_a,
  output int              high_b
);
  int         tally_a = 0;
  int         tally_b = 0;
  logic [1:0] level;

  // a floating pin reads the pull-down, never the last drive
  assign level = pin_o & pin_oe;
  assign high_a = tally_a;
  assign high_b = tally_b;

  // tally the pin level once per clock
  always @(posedge ref_clk) begin
    tally_a <= tally_a + int'(level[0]);
    tally_b <= tally_b + int'(level[1]);
  end
endmodule // tpwm_load
